// [scpm_defines.vh]
`ifndef SCPM_DEFINES_VH
`define SCPM_DEFINES_VH
// Register byte offsets
`define SCPM_OFF_SYSCLK       8'h00
`define SCPM_OFF_FRC          8'h04
`define SCPM_OFF_FXT          8'h08
`define SCPM_OFF_SXT          8'h0c
`define SCPM_OFF_IRQ_STAT     8'h10
`define SCPM_OFF_IRQ_MASK     8'h14
`define SCPM_OFF_MODE         8'h18
// System clock control fields
`define SCPM_CKS_HI           7
`define SCPM_CKS_LO           5
`define SCPM_FHS_BIT          3
`define SCPM_FSS_BIT          2
`define SCPM_FKEEP_BIT        1
`define SCPM_SKEEP_BIT        0
`define SCPM_CKS_SUB          3'h7
// Oscillator control fields
`define SCPM_EN_BIT           0
`define SCPM_STABLE_BIT       1
`define SCPM_FREQ_HI          3
`define SCPM_FREQ_LO          2
`define SCPM_XT_MODE_BIT      2
// Reset values
`define SCPM_RST_SYSCLK       8'h00
`define SCPM_RST_FRC_EN       1'b1
`define SCPM_RST_FRC_FREQ     2'h0
`define SCPM_SXT_SPEEDUP      1'b1
// Interrupt status bits
`define SCPM_IRQ_W            5
`define SCPM_IRQ_SWITCH       3
`define SCPM_IRQ_WAKE         4
// Timing: settle in ns, system clock period in ns
`define SCPM_SETTLE_NS        1600
`define SCPM_CLK_NS           100
`define SCPM_SW_CORE_TICKS    3'h4
`endif

// [scpm_sysclk_chk.sv]
`timescale 1ns/100ps
module scpm_sysclk_chk (
	input wire        ref_clk_i,        // Clock
	input wire        rstn_i,           // Reset
	input wire        wb_cyc_i,         // Cycle
	input wire        wb_stb_i,         // Strobe
	input wire [31:0] wb_dat_o,         // Read data
	input wire        wb_ack_o,         // Ack
	input wire        frc_tick_i,       // Fast RC edge
	input wire        fxt_tick_i,       // Fast crystal edge
	input wire        src_tick_i,       // Slow RC edge
	input wire        sxt_tick_i,       // Slow crystal edge
	input wire        halt_i,           // Stop
	input wire        wake_i,           // Wake
	input wire        watchdog_en_i,    // Watchdog on
	input wire        core_clk_en_o,    // Core tick
	input wire        sub_clk_en_o,     // Sub tick
	input wire        slow_rc_clk_en_o, // Slow RC tick
	input wire        cpu_run_o         // CPU running
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits set");
	a_cpu_stop: assert property (halt_i && cpu_run_o |-> ##2 !cpu_run_o)
		else $error("cpu did not stop");
	a_cpu_wake: assert property (wake_i && !cpu_run_o |-> ##2 cpu_run_o)
		else $error("cpu did not wake");
	a_sub_origin: assert property (sub_clk_en_o |-> $past(src_tick_i || sxt_tick_i))
		else $error("sub tick without cause");
	a_core_origin: assert property (core_clk_en_o |->
		$past(frc_tick_i || fxt_tick_i || src_tick_i || sxt_tick_i))
		else $error("core tick without cause");
	a_slow_rc_kept: assert property (
		((cpu_run_o && !$past(halt_i)) || watchdog_en_i) && src_tick_i |=> slow_rc_clk_en_o)
		else $error("slow rc tick lost");
	c_halt: cover property (halt_i && cpu_run_o);
	c_wake: cover property (wake_i && !cpu_run_o);
	c_wd_sleep: cover property (watchdog_en_i && !cpu_run_o && slow_rc_clk_en_o);
endmodule // scpm_sysclk_chk

// [scpm_sysclk_ctrl.v]
// Operation
// - Clock-select codes 0..6 take the fast path, code 7 the sub clock.
// - Fast clock comes from fast crystal or fast RC per fast source bit.
// - Sub clock comes from slow crystal or slow RC per slow source bit.
// - In fast mode the fast clock is divided by 1 to 64 before core use.
// - Fast mode: CPU runs, fast, sub and slow RC clocks all active.
// - Slow mode: CPU on sub clock; fast clock follows its enable bit.
// - Stop with both keep bits low: sleep, CPU and all clocks stop except slow RC while the watchdog is on.
// - Stop with only slow keep: idle slow only, core runs only on code 7.
// - Stop with both keep bits high: CPU stops, all clocks keep running.
// - Stop with only fast keep: idle fast only, core runs only on codes 0..6.
// - Slow RC runs always except in sleep, where it follows the watchdog.
// - System control: select bits 7:5, sources 3 and 2, keeps 1 and 0.
// - Oscillator registers: enable bit 0, stable bit 1, mode or freq above.
// - Codes 0..6 divide by 1,2,4,8,16,32,64; code 7 gives the sub clock.
// - Source select 0 picks the RC oscillator, 1 picks the crystal.
// - Freq change, or enable change of a source not forced on, clears stable; new freq applies once stable.
// - Source change completes after 4 core ticks plus one target tick.
`timescale 1ns/100ps
`include "scpm_defines.vh"
module scpm_sysclk_ctrl #(
	parameter SETTLE_CYCLES = (`SCPM_SETTLE_NS + `SCPM_CLK_NS - 1) / `SCPM_CLK_NS
) (
	input  wire        ref_clk_i,        // System clock, 10 MHz
	input  wire        rstn_i,           // Async reset, active low
	input  wire        wb_cyc_i,         // Wishbone cycle
	input  wire        wb_stb_i,         // Wishbone strobe
	input  wire        wb_we_i,          // Wishbone write enable
	input  wire [7:0]  wb_adr_i,         // Wishbone byte address
	input  wire [3:0]  wb_sel_i,         // Wishbone byte selects
	input  wire [31:0] wb_dat_i,         // Wishbone write data
	output reg  [31:0] wb_dat_o,         // Wishbone read data
	output reg         wb_ack_o,         // Wishbone acknowledge
	input  wire        frc_tick_i,       // Fast RC oscillator edge
	input  wire        fxt_tick_i,       // Fast crystal oscillator edge
	input  wire        src_tick_i,       // Slow RC oscillator edge
	input  wire        sxt_tick_i,       // Slow crystal oscillator edge
	input  wire        halt_i,           // CPU stop instruction pulse
	input  wire        wake_i,           // Wake-up pulse
	input  wire        watchdog_en_i,    // Watchdog timer enabled
	output reg         core_clk_en_o,    // Core clock tick
	output reg         fast_clk_en_o,    // Fast clock tick to peripherals
	output reg         sub_clk_en_o,     // Sub clock tick to peripherals
	output reg         slow_rc_clk_en_o, // Slow RC clock tick
	output reg         cpu_run_o,        // CPU running
	output wire        frc_run_o,        // Fast RC oscillator on
	output wire        fxt_run_o,        // Fast crystal oscillator on
	output wire        src_run_o,        // Slow RC oscillator on
	output wire        sxt_run_o,        // Slow crystal oscillator on
	output reg  [1:0]  frc_freq_o,       // Applied fast RC frequency
	output wire        irq_o             // Interrupt, active high level
);

	localparam MODE_RUN   = 3'h0;
	localparam MODE_SLEEP = 3'h1;
	localparam MODE_IDLE_SLOW_ONLY = 3'h2;
	localparam MODE_IDLE_BOTH_RUNNING = 3'h3;
	localparam MODE_IDLE_FAST_ONLY = 3'h4;

	reg  [7:0]  sysclk_q;
	reg         frc_en_q;
	reg  [1:0]  frc_freq_q;
	reg         fxt_en_q;
	reg         fxt_mode_q;
	reg         sxt_en_q;
	reg  [4:0]  irq_stat_q;
	reg  [4:0]  irq_mask_q;
	reg  [2:0]  mode_q;
	reg  [2:0]  halt_cks_q;
	reg  [4:0]  cur_sel_q;
	reg  [2:0]  sw_cnt_q;
	reg  [5:0]  div_q;
	wire [2:0]  stable_q;
	reg  [2:0]  osc_on_q;
	reg  [2:0]  restart_q;
	reg  [31:0] rd_d;
	reg  [5:0]  div_mask;

	wire        wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	wire [7:0]  wdat    = wb_dat_i[7:0];
	wire [4:0]  req_sel = {sysclk_q[7:5], sysclk_q[3:2]};
	wire [2:0]  cur_cks = cur_sel_q[4:2];
	wire        run     = (mode_q == MODE_RUN);

	// Last count of the settle counter, cut to the counter width on purpose
	localparam integer SETTLE_LAST = SETTLE_CYCLES - 1;

	// fast source pick per applied selection
	wire fast_tick_raw = cur_sel_q[1] ? fxt_tick_i : frc_tick_i;
	// sub source pick per applied selection
	wire sub_tick_raw  = cur_sel_q[0] ? sxt_tick_i : src_tick_i;
	// target tick of the requested source
	wire tgt_tick = (req_sel[4:2] == `SCPM_CKS_SUB) ?
		(req_sel[0] ? sxt_tick_i : src_tick_i) :
		(req_sel[1] ? fxt_tick_i : frc_tick_i);

	// in run mode the fast clock is forced on in fast mode and follows its enable bit in slow mode
	reg fast_on;
	reg sub_on;
	reg core_on;
	always @*
	begin
		fast_on = 1'b0;
		sub_on  = 1'b0;
		core_on = 1'b0;
		case (mode_q)
			MODE_RUN:
			begin
				fast_on = (cur_cks != `SCPM_CKS_SUB) |
					(cur_sel_q[1] ? fxt_en_q : frc_en_q);
				sub_on  = 1'b1;
				core_on = 1'b1;
			end
			MODE_IDLE_SLOW_ONLY:
			begin
				sub_on  = 1'b1;
				core_on = (halt_cks_q == `SCPM_CKS_SUB);
			end
			MODE_IDLE_BOTH_RUNNING:
			begin
				fast_on = 1'b1;
				sub_on  = 1'b1;
				core_on = 1'b1;
			end
			MODE_IDLE_FAST_ONLY:
			begin
				fast_on = 1'b1;
				core_on = (halt_cks_q != `SCPM_CKS_SUB);
			end
			default:
			begin
				fast_on = 1'b0;
				sub_on  = 1'b0;
				core_on = 1'b0;
			end
		endcase
	end

	// Oscillator run requests: selected source forced, others per enable
	wire frc_want = fast_on & (~cur_sel_q[1] | frc_en_q);
	wire fxt_want = fast_on & (cur_sel_q[1] | fxt_en_q);
	wire sxt_want = sub_on & (cur_sel_q[0] | sxt_en_q);
	assign frc_run_o = frc_want;
	assign fxt_run_o = fxt_want;
	assign sxt_run_o = sxt_want;
	// slow RC stops only in sleep with watchdog off
	assign src_run_o = (mode_q != MODE_SLEEP) | watchdog_en_i;

	always @*
	begin
		case (cur_cks)
			3'h0: div_mask = 6'h00;
			3'h1: div_mask = 6'h01;
			3'h2: div_mask = 6'h03;
			3'h3: div_mask = 6'h07;
			3'h4: div_mask = 6'h0f;
			3'h5: div_mask = 6'h1f;
			3'h6: div_mask = 6'h3f;
			default: div_mask = 6'h00;
		endcase
	end

	// divide the fast clock by 1 to 64
	wire div_tick = fast_tick_raw & ((div_q & div_mask) == div_mask);
	// core tick from divided fast path or sub clock
	wire core_tick = (cur_cks == `SCPM_CKS_SUB) ? sub_tick_raw : div_tick;

	// Registered clock enables keep gating glitch-free
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			div_q            <= 6'h00;
			core_clk_en_o    <= 1'b0;
			fast_clk_en_o    <= 1'b0;
			sub_clk_en_o     <= 1'b0;
			slow_rc_clk_en_o <= 1'b0;
			cpu_run_o        <= 1'b0;
		end
		else
		begin
			if (fast_tick_raw)
				div_q <= div_q + 6'h01;
			// gated enables follow the sampled low-power mode
			core_clk_en_o    <= core_tick & core_on;
			fast_clk_en_o    <= fast_tick_raw & fast_on;
			sub_clk_en_o     <= sub_tick_raw & sub_on;
			slow_rc_clk_en_o <= src_tick_i & src_run_o;
			cpu_run_o        <= run;
		end
	end

	// stable counters, one per controlled oscillator
	wire [2:0] osc_on = {sxt_want, fxt_want, frc_want};
	wire [2:0] restart;
	wire [2:0] stable_rise;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_osc
			reg [15:0] cnt_q;
			reg        stab_q;
			assign stable_q[gi]    = stab_q;
			assign restart[gi]     = (osc_on[gi] & ~osc_on_q[gi]) | restart_q[gi];
			assign stable_rise[gi] = osc_on[gi] & ~stable_q[gi] & ~restart[gi] &
				(cnt_q == SETTLE_LAST[15:0]);
			// Settle count; stable clears on start and sets when settled
			always @(posedge ref_clk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					cnt_q  <= 16'h0000;
					stab_q <= 1'b0;
				end
				else if (!osc_on[gi] || restart[gi])
				begin
					cnt_q  <= 16'h0000;
					stab_q <= 1'b0;
				end
				else if (stable_rise[gi])
					stab_q <= 1'b1;
				else if (!stable_q[gi])
					cnt_q <= cnt_q + 16'h0001;
			end
		end
	endgenerate

	// Register file, mode machine, switching and interrupts
	always @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sysclk_q   <= `SCPM_RST_SYSCLK;
			frc_en_q   <= `SCPM_RST_FRC_EN;
			frc_freq_q <= `SCPM_RST_FRC_FREQ;
			frc_freq_o <= `SCPM_RST_FRC_FREQ;
			fxt_en_q   <= 1'b0;
			fxt_mode_q <= 1'b0;
			sxt_en_q   <= 1'b0;
			irq_stat_q <= 5'h00;
			irq_mask_q <= 5'h00;
			mode_q     <= MODE_RUN;
			halt_cks_q <= 3'h0;
			cur_sel_q  <= 5'h00;
			sw_cnt_q   <= 3'h0;
			osc_on_q   <= 3'h0;
			restart_q  <= 3'h0;
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h00000000;
		end
		else
		begin
			osc_on_q  <= osc_on;
			restart_q <= 3'h0;
			wb_ack_o  <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o)
				wb_dat_o <= rd_d;
			// apply new fast RC frequency only once stable
			// A pending restart means the flag is about to clear: hold the old value
			if (stable_q[0] && !restart[0])
				frc_freq_o <= frc_freq_q;
			if (wr_en)
			begin
				case (wb_adr_i)
					`SCPM_OFF_SYSCLK:
						sysclk_q <= {wdat[7:5], 1'b0, wdat[3:0]};
					`SCPM_OFF_FRC:
					begin
						frc_en_q   <= wdat[`SCPM_EN_BIT];
						frc_freq_q <= wdat[`SCPM_FREQ_HI:`SCPM_FREQ_LO];
						if (wdat[`SCPM_FREQ_HI:`SCPM_FREQ_LO] != frc_freq_q)
							restart_q[0] <= 1'b1;
					end
					`SCPM_OFF_FXT:
					begin
						fxt_en_q <= wdat[`SCPM_EN_BIT];
						if (!fxt_en_q)
							fxt_mode_q <= wdat[`SCPM_XT_MODE_BIT];
					end
					`SCPM_OFF_SXT:
						sxt_en_q <= wdat[`SCPM_EN_BIT];
					`SCPM_OFF_IRQ_MASK:
						irq_mask_q <= wdat[4:0];
					default:
						sysclk_q <= sysclk_q;
				endcase
			end
			// four core ticks, then adopt on a target tick
			if (req_sel == cur_sel_q)
				sw_cnt_q <= 3'h0;
			else if (sw_cnt_q != `SCPM_SW_CORE_TICKS)
			begin
				if (core_tick)
					sw_cnt_q <= sw_cnt_q + 3'h1;
			end
			else if (tgt_tick)
			begin
				cur_sel_q <= req_sel;
				sw_cnt_q  <= 3'h0;
			end
			// sample keep bits and select at the stop instruction
			case (mode_q)
				MODE_RUN:
					if (halt_i)
					begin
						halt_cks_q <= cur_cks;
						case ({sysclk_q[`SCPM_FKEEP_BIT], sysclk_q[`SCPM_SKEEP_BIT]})
							2'b00: mode_q <= MODE_SLEEP;
							2'b01: mode_q <= MODE_IDLE_SLOW_ONLY;
							2'b11: mode_q <= MODE_IDLE_BOTH_RUNNING;
							default: mode_q <= MODE_IDLE_FAST_ONLY;
						endcase
					end
				MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_BOTH_RUNNING, MODE_IDLE_FAST_ONLY:
					if (wake_i)
						mode_q <= MODE_RUN;
				default:
					mode_q <= MODE_RUN;
			endcase
			// Sticky events; a set in the clear cycle wins
			irq_stat_q <= (irq_stat_q &
				~((wr_en && wb_adr_i == `SCPM_OFF_IRQ_STAT) ? wdat[4:0] : 5'h00)) |
				{(wake_i & ~run),
				(sw_cnt_q == `SCPM_SW_CORE_TICKS) & tgt_tick & (req_sel != cur_sel_q),
				stable_rise};
		end
	end

	// Read mux; unmapped addresses read zero
	always @*
	begin
		rd_d = 32'h00000000;
		case (wb_adr_i)
			`SCPM_OFF_SYSCLK:    rd_d[7:0] = {sysclk_q[7:5], 1'b0, sysclk_q[3:0]};
			`SCPM_OFF_FRC:       rd_d[7:0] = {4'h0, frc_freq_q, stable_q[0], frc_en_q};
			`SCPM_OFF_FXT:       rd_d[7:0] = {5'h00, fxt_mode_q, stable_q[1], fxt_en_q};
			`SCPM_OFF_SXT:       rd_d[7:0] = {5'h00, `SCPM_SXT_SPEEDUP, stable_q[2], sxt_en_q};
			`SCPM_OFF_IRQ_STAT:  rd_d[7:0] = {3'h0, irq_stat_q};
			`SCPM_OFF_IRQ_MASK:  rd_d[7:0] = {3'h0, irq_mask_q};
			`SCPM_OFF_MODE:      rd_d[7:0] = {cur_sel_q, mode_q};
			default:             rd_d = 32'h00000000;
		endcase
	end

	assign irq_o = |(irq_stat_q & irq_mask_q);

endmodule // scpm_sysclk_ctrl

// [test_sysclk_and_power_mode_ctrl.sv]
`timescale 1ns/100ps
module test_sysclk_and_power_mode_ctrl;
	logic        ref_clk_i = 1'b0, rstn_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0, halt_i = 1'b0, wake_i = 1'b0, watchdog_en_i = 1'b0;
	logic        frc_tick_i = 1'b0, fxt_tick_i = 1'b0, src_tick_i = 1'b0, sxt_tick_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic        wb_ack_o, core_clk_en_o, fast_clk_en_o, sub_clk_en_o, slow_rc_clk_en_o;
	logic        cpu_run_o, frc_run_o, fxt_run_o, src_run_o, sxt_run_o, irq_o;
	logic [1:0]  frc_freq_o, keep;
	logic [2:0]  code;
	logic [3:0]  seen;
	logic [7:0]  v;
	int          n_mismatch = 0, n_tests = 0, n_cyc = 0, i;
	int          seed = 32'h1026efa0;
	int          mtab[4] = '{1, 2, 4, 3};
	scpm_sysclk_ctrl #(.SETTLE_CYCLES(8)) i_dut (.*);
	// Clock
	always #50 ref_clk_i = ~ref_clk_i;
	// Random oscillator edges and run limit
	always @(posedge ref_clk_i)
	begin
		{frc_tick_i, fxt_tick_i, src_tick_i, sxt_tick_i} <= 4'($random(seed));
		n_cyc <= n_cyc + 1;
		if (n_cyc == 5000)
		begin
			n_mismatch++;
			test_done;
		end
	end
	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic tk(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic chk(input string nm, input int e, input logic [31:0] g);
		n_tests++;
		if (g !== 32'(e))
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
		do
			@(posedge ref_clk_i);
		while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge ref_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input int e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(nm, e, q);
	endtask
	task automatic pulse(input logic stop);
		if (stop)
			halt_i <= 1'b1;
		else
			wake_i <= 1'b1;
		tk(1);
		halt_i <= 1'b0;
		wake_i <= 1'b0;
		tk(3);
	endtask
	// Main sequence
	initial
	begin
		tk(3);
		rstn_i <= 1'b1;
		tk(20);
		rc("sysclk", 8'h00, 8'h00);
		rc("frc", 8'h04, 8'h03);
		rc("fxt", 8'h08, 8'h00);
		rc("sxt", 8'h0c, 8'h04);
		wr(8'h1c, 8'hff);
		rc("unmapped", 8'h1c, 0);
		for (i = 0; i < 4; i++)
		begin
			v = 8'($random(seed));
			wr(8'h00, v);
			rc("sysclk rw", 8'h00, v & 8'hef);
		end
		wr(8'h00, 8'h00);
		tk(1000);
		wr(8'h0c, 8'h01);
		rc("sxt start", 8'h0c, 8'h05);
		tk(16);
		rc("sxt stable", 8'h0c, 8'h07);
		wr(8'h14, 8'h04);
		chk("irq set", 1, irq_o);
		wr(8'h10, 8'h04);
		chk("irq clear", 0, irq_o);
		wr(8'h08, 8'h04);
		wr(8'h08, 8'h05);
		wr(8'h08, 8'h01);
		tk(16);
		rc("fxt mode", 8'h08, 8'h07);
		wr(8'h04, 8'h09);
		rc("frc freq", 8'h04, 8'h09);
		chk("freq held", 0, frc_freq_o);
		tk(16);
		rc("frc settled", 8'h04, 8'h0b);
		chk("freq applied", 2, frc_freq_o);
		for (i = 0; i < 8; i++)
		begin
			code = (i < 4) ? 3'h0 : 3'h7;
			keep = 2'(i);
			watchdog_en_i <= code[0];
			wr(8'h00, {code, 3'b000, keep});
			tk(60);
			rc("applied select", 8'h18, {code, 5'h0});
			pulse(1'b1);
			chk("cpu run", 0, cpu_run_o);
			rc("mode", 8'h18, {code, 5'h0} | mtab[keep]);
			chk("slow rc on", keep != 2'h0 || code[0], src_run_o);
			chk("fast rc on", keep[1], frc_run_o);
			chk("fast xtal on", keep[1], fxt_run_o);
			chk("slow xtal on", keep[0], sxt_run_o);
			seen = 4'h0;
			repeat (40) @(posedge ref_clk_i)
				seen = seen | {core_clk_en_o, fast_clk_en_o, sub_clk_en_o, slow_rc_clk_en_o};
			chk("core", code[0] ? keep[0] : keep[1], seen[3]);
			chk("fast", keep[1], seen[2]);
			chk("sub", keep[0], seen[1]);
			chk("slow rc", keep != 2'h0 || code[0], seen[0]);
			pulse(1'b0);
			chk("cpu wake", 1, cpu_run_o);
		end
		test_done;
	end
endmodule // test_sysclk_and_power_mode_ctrl
bind scpm_sysclk_ctrl scpm_sysclk_chk i_chk (.*);
